// >>> src/hcc_params.svh
// Constants for the host control command block: codes, offsets, fields, timing
`ifndef HCC_PARAMS_SVH
`define HCC_PARAMS_SVH
// Timing, in Hz and ms
`define HCC_REF_HZ       32'h0098_9680
`define HCC_POLL_HZ      32'h0000_0020
`define HCC_PWM_HZ       32'h0000_0064
`define HCC_PWM_STEPS    32'h0000_0064
`define HCC_MS_PER_S     32'h0000_03E8
`define HCC_RESET_MS     32'h0000_03E8
`define HCC_KEY_LONG_MS  32'h0000_0FA0
`define HCC_KEY_SHORT_MS 32'h0000_00FA
// Command and reply codes
`define HCC_ACK      8'h40
`define HCC_ERR      8'hC0
`define HCC_T_PWR    8'h1C
`define HCC_T_WDOG   8'h1D
`define HCC_T_STAT   8'h1E
`define HCC_T_TEXT   8'h1F
`define HCC_T_BAUD   8'h21
`define HCC_T_PIN    8'h22
`define HCC_STAT_LEN 8'h0F
// Power-switch mask bit positions
`define HCC_M_AUTO  0
`define HCC_M_RINV  1
`define HCC_M_PINV  2
`define HCC_M_BLANK 4
`define HCC_M_KRST  5
`define HCC_M_KON   6
`define HCC_M_KOFF  7
// Reset values and limits
`define HCC_PULSE_DEF 8'h20
`define HCC_PULSE_HLD 8'hFF
`define HCC_CFG_DEF   4'h2
`define HCC_CFG_SENSE 4'h3
`define HCC_VAL_MAX   8'h64
`define HCC_PIN_N     32'h0000_0005
`define HCC_BUF_N     32'h0000_0012
`define HCC_COLS      32'h0000_0010
`define HCC_DISP_N    32'h0000_0020
// Register byte addresses
`define HCC_A_TYPE     7'h00
`define HCC_A_LEN      7'h01
`define HCC_A_GO       7'h02
`define HCC_A_RTYPE    7'h03
`define HCC_A_RLEN     7'h04
`define HCC_A_STAT     7'h05
`define HCC_A_PIN      7'h08
`define HCC_A_PIN_END  7'h0C
`define HCC_A_BUF      7'h10
`define HCC_A_BUF_END  7'h21
`define HCC_A_RDAT     7'h30
`define HCC_A_RDAT_END 7'h3E
`define HCC_A_DISP     7'h40
`define HCC_A_DISP_END 7'h5F
`endif

// >>> src/hcc_pkg.sv
// Types shared by the host control command block
package hcc_pkg;
	typedef enum logic [1:0] {
		HCC_P_IDLE = 2'b00,
		HCC_P_RST  = 2'b01,
		HCC_P_PWR  = 2'b10,
		HCC_P_HOLD = 2'b11
	} hcc_pulse_e;
	typedef logic [7:0] hcc_byte_t;
endpackage : hcc_pkg

// >>> src/hcc_tick_gen.sv
// Free-running divider giving a one-cycle enable every PERIOD clocks
`timescale 1ns/100ps
`default_nettype none
module hcc_tick_gen
	import hcc_pkg::*;
#(
	parameter int unsigned PERIOD = 1000
) (
	input  wire logic i_ref_clk,
	input  wire logic i_resetn,
	output logic      o_tick
);
	logic [31:0] count;

	// Count to PERIOD-1, then pulse and wrap
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			count  <= 32'h0000_0000;
			o_tick <= 1'b0;
		end else if (count >= PERIOD - 1) begin
			count  <= 32'h0000_0000;
			o_tick <= 1'b1;
		end else begin
			count  <= count + 32'h0000_0001;
			o_tick <= 1'b0;
		end
	end
endmodule : hcc_tick_gen
`default_nettype wire

// >>> src/hcc_host_ctrl.sv
// Host power, watchdog, text and pin command interpreter
// What this block does
// - Accepted commands reply with type OR 0x40; all but status 0x1E reply empty.
// - Power command 0x1C takes mask; 0x10 blank, 0x20 key reset, 0x40 key on.
// - Mask 0x80 enables key power-off; 0x01 senses line polarity automatically.
// - Without auto sense, 0x02 inverts reset line, 0x04 inverts power line.
// - Second byte sets power pulse in 1/32 s units, 1 to 254.
// - Pulse byte 255 holds power line until host power state changes.
// - Third byte 1 selects rail sense, 0 selects pin 1 as alive input.
// - Host off: keypad still watched; alive rising triggers a full reboot.
// - Watchdog 0x1D: 0 disables, 1-255 seconds, reissue restarts the count.
// - Watchdog expiry resets host once, then stays off until rearmed.
// - Watchdog starts disabled after power-up.
// - Status 0x1E returns 15 bytes in the fixed order.
// - Text 0x1F: 3-18 bytes, column 0-15, row 0-1, then characters.
// - Baud 0x21 acknowledges at old rate, then switches rate.
// - Baud code 0 is 19200, 1 is 115200; default 19200.
// - Pin 0x22: 2 bytes value only, 3 bytes with config; pins 0-4.
// - Value 0 low, 100 high, 1-99 duty at 100 Hz, above 100 invalid.
// - Low three config bits select drive mode; 110 reserved.
// - Config bit 3 gives pin to user; only 0-15 valid.
// - Pins sampled at 32 Hz; edges latched until host query.
// - Reset and power lines float when idle, driven only during pulses.
// - Host reset is a 1 second pulse on the reset line.
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "hcc_params.svh"
module hcc_host_ctrl
	import hcc_pkg::*;
#(
	parameter int unsigned P_POLL_CYC = `HCC_REF_HZ / `HCC_POLL_HZ,
	parameter int unsigned P_SEC_CYC  = `HCC_REF_HZ
) (
	input  wire logic         i_ref_clk,
	input  wire logic         i_resetn,
	input  wire logic [6:0]   i_addr,
	input  wire logic [7:0]   i_wdata,
	input  wire logic         i_wr,
	input  wire logic         i_rd,
	output logic      [7:0]   o_rdata,
	input  wire logic         i_reply_sent,
	output logic              o_reply_ready,
	input  wire logic [103:0] i_ext_status,
	input  wire logic [4:0]   i_pin_in,
	output logic      [4:0]   o_pin_out,
	output logic      [4:0]   o_pin_oe,
	input  wire logic         i_rail_sense,
	input  wire logic         i_key_check,
	input  wire logic         i_key_cancel,
	output logic              o_blank,
	output logic              o_self_reboot,
	output logic              o_baud_sel
);
	localparam int unsigned PWM_CYC = `HCC_REF_HZ / (`HCC_PWM_HZ * `HCC_PWM_STEPS);
	localparam logic [7:0] RST_TICKS = 8'(`HCC_RESET_MS * `HCC_POLL_HZ / `HCC_MS_PER_S);
	localparam logic [7:0] LONG_TICKS = 8'(`HCC_KEY_LONG_MS * `HCC_POLL_HZ / `HCC_MS_PER_S);
	localparam logic [7:0] SHORT_TICKS = 8'(`HCC_KEY_SHORT_MS * `HCC_POLL_HZ / `HCC_MS_PER_S);
	localparam logic [6:0] STEP_LAST = 7'(`HCC_PWM_STEPS - 1);

	hcc_byte_t  cmd_type, cmd_len, reply_type, reply_len, rd_val;
	hcc_byte_t  cmd_buf [`HCC_BUF_N];
	hcc_byte_t  disp [`HCC_DISP_N];
	hcc_byte_t  pin_val [`HCC_PIN_N];
	logic [3:0] pin_cfg [`HCC_PIN_N];
	hcc_byte_t  pwr_mask, pulse_len, wd_count, pulse_cnt, chk_hold, cxl_hold;
	hcc_byte_t  b0, b1, b2;
	hcc_pulse_e state;
	logic [4:0] pin_m, pin_s, pin_state, pin_rise, pin_fall, rise_set, fall_set, pin_clr;
	logic [2:0] misc_m, misc_s, pidx;
	logic [6:0] step;
	logic [3:0] eidx;
	logic       poll_tick, sec_tick, pwm_tick, cmd_ok, go, exec;
	logic       ex_pwr, ex_wdog, ex_stat, ex_text, ex_baud, ex_pin;
	logic       sense_sel, host_alive, alive_q, baud_next, baud_pend, pin_primed;
	logic       wd_fire, rst_req, pwr_req, sense_start, rst_idle, pwr_idle;
	logic       rst_act, pwr_act, rst_drive, pwr_drive, pin_hit, buf_hit, rdat_hit, disp_hit;

	// Saturating hold counter step, shared by both keys
	function automatic hcc_byte_t sat_inc(input hcc_byte_t v);
		return (v == 8'hFF) ? v : 8'(v + 8'h01);
	endfunction : sat_inc

	// Requested level of a pin in the current PWM step
	function automatic logic pwm_level(input hcc_byte_t v, input logic [6:0] s);
		return (v >= `HCC_VAL_MAX) || ((v != 8'h00) && ({1'b0, s} < v));
	endfunction : pwm_level

	// {oe, out} for a drive mode; resistive and slow edges show as released or strong
	function automatic logic [1:0] drive_of(input logic [2:0] mode, input logic lvl);
		logic [1:0] r;
		r = 2'b00;
		unique case (mode)
			3'b000, 3'b100: r = lvl ? 2'b11 : 2'b00;
			3'b001, 3'b101: r = {1'b1, lvl};
			3'b011, 3'b111: r = lvl ? 2'b00 : 2'b10;
			3'b010, 3'b110: r = 2'b00;
		endcase
		return r;
	endfunction : drive_of

	// Slow rates as enables from one divider each
	hcc_tick_gen #(.PERIOD(P_POLL_CYC)) u_poll (
		.i_ref_clk(i_ref_clk),
		.i_resetn (i_resetn),
		.o_tick   (poll_tick)
	);
	hcc_tick_gen #(.PERIOD(P_SEC_CYC)) u_sec (
		.i_ref_clk(i_ref_clk),
		.i_resetn (i_resetn),
		.o_tick   (sec_tick)
	);
	hcc_tick_gen #(.PERIOD(PWM_CYC)) u_pwm (
		.i_ref_clk(i_ref_clk),
		.i_resetn (i_resetn),
		.o_tick   (pwm_tick)
	);

	// Two-stage synchronisers for every pin-level input
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pin_m  <= 5'h00;
			pin_s  <= 5'h00;
			misc_m <= 3'h0;
			misc_s <= 3'h0;
		end else begin
			pin_m  <= i_pin_in;
			pin_s  <= pin_m;
			misc_m <= {i_rail_sense, i_key_check, i_key_cancel};
			misc_s <= misc_m;
		end
	end

	// Bus decode
	assign b0       = cmd_buf[0];
	assign b1       = cmd_buf[1];
	assign b2       = cmd_buf[2];
	assign go       = i_wr && (i_addr == `HCC_A_GO);
	assign pin_hit  = (i_addr >= `HCC_A_PIN) && (i_addr <= `HCC_A_PIN_END);
	assign buf_hit  = (i_addr >= `HCC_A_BUF) && (i_addr <= `HCC_A_BUF_END);
	assign rdat_hit = (i_addr >= `HCC_A_RDAT) && (i_addr <= `HCC_A_RDAT_END);
	assign disp_hit = (i_addr >= `HCC_A_DISP) && (i_addr <= `HCC_A_DISP_END);
	assign pidx     = 3'(i_addr - `HCC_A_PIN);

	// Command staging registers written by software
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cmd_type <= 8'h00;
			cmd_len  <= 8'h00;
			for (int k = 0; k < `HCC_BUF_N; k++) begin
				cmd_buf[k] <= 8'h00;
			end
		end else if (i_wr && i_addr == `HCC_A_TYPE) begin
			cmd_type <= i_wdata;
		end else if (i_wr && i_addr == `HCC_A_LEN) begin
			cmd_len <= i_wdata;
		end else if (i_wr && buf_hit) begin
			cmd_buf[5'(i_addr - `HCC_A_BUF)] <= i_wdata;
		end
	end

	// Length and field checks; anything unknown is refused
	always_comb begin
		cmd_ok = 1'b0;
		unique case (cmd_type)
			`HCC_T_PWR:  cmd_ok = (cmd_len >= 8'h01) && (cmd_len <= 8'h03)
				&& (cmd_len < 8'h02 || b1 != 8'h00) && (cmd_len < 8'h03 || b2 <= 8'h01);
			`HCC_T_WDOG: cmd_ok = (cmd_len == 8'h01);
			`HCC_T_STAT: cmd_ok = (cmd_len == 8'h00);
			`HCC_T_TEXT: cmd_ok = (cmd_len >= 8'h03) && (cmd_len <= 8'h12)
				&& (b0 <= 8'h0F) && (b1 <= 8'h01);
			`HCC_T_BAUD: cmd_ok = (cmd_len == 8'h01) && (b0 <= 8'h01);
			`HCC_T_PIN:  cmd_ok = (cmd_len == 8'h02 || cmd_len == 8'h03) && (b0 <= 8'h04)
				&& (b1 <= `HCC_VAL_MAX)
				&& (cmd_len == 8'h02 || (b2 <= 8'h0F && b2[2:0] != 3'b110));
			default:     cmd_ok = 1'b0;
		endcase
	end

	assign exec    = go && cmd_ok;
	assign ex_pwr  = exec && (cmd_type == `HCC_T_PWR);
	assign ex_wdog = exec && (cmd_type == `HCC_T_WDOG);
	assign ex_stat = exec && (cmd_type == `HCC_T_STAT);
	assign ex_text = exec && (cmd_type == `HCC_T_TEXT);
	assign ex_baud = exec && (cmd_type == `HCC_T_BAUD);
	assign ex_pin  = exec && (cmd_type == `HCC_T_PIN);

	// Reply header; a new command wins over the framer's sent pulse
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			reply_type    <= 8'h00;
			reply_len     <= 8'h00;
			o_reply_ready <= 1'b0;
		end else if (go) begin
			reply_type    <= cmd_ok ? (cmd_type | `HCC_ACK) : (cmd_type | `HCC_ERR);
			reply_len     <= ex_stat ? `HCC_STAT_LEN : 8'h00;
			o_reply_ready <= 1'b1;
		end else if (i_reply_sent) begin
			o_reply_ready <= 1'b0;
		end
	end

	// Rate change waits until the acknowledge has gone out at the old rate
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			baud_next  <= 1'b0;
			baud_pend  <= 1'b0;
			o_baud_sel <= 1'b0;
		end else if (ex_baud) begin
			baud_next <= b0[0];
			baud_pend <= 1'b1;
		end else if (baud_pend && i_reply_sent) begin
			o_baud_sel <= baud_next;
			baud_pend  <= 1'b0;
		end
	end

	// Power-switch configuration
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pwr_mask  <= 8'h00;
			pulse_len <= `HCC_PULSE_DEF;
			sense_sel <= 1'b1;
		end else if (ex_pwr) begin
			pwr_mask <= b0;
			if (cmd_len >= 8'h02) begin
				pulse_len <= b1;
			end
			if (cmd_len == 8'h03) begin
				sense_sel <= b2[0];
			end
		end
	end

	// Watchdog seconds counter; zero means disarmed, also after power-up
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wd_count <= 8'h00;
		end else if (ex_wdog) begin
			wd_count <= b0;
		end else if (sec_tick && wd_count != 8'h00) begin
			wd_count <= 8'(wd_count - 8'h01);
		end
	end
	// Expiry drops the count to zero, so no repeat until rearmed
	assign wd_fire = sec_tick && !ex_wdog && (wd_count == 8'h01);

	// Host alive sense and reboot on its rise
	assign host_alive = sense_sel ? misc_s[2] : pin_s[1];
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			alive_q       <= 1'b0;
			o_self_reboot <= 1'b0;
			o_blank       <= 1'b0;
		end else begin
			alive_q       <= host_alive;
			o_self_reboot <= host_alive && !alive_q;
			o_blank       <= pwr_mask[`HCC_M_BLANK] && !host_alive;
		end
	end

	// Key hold timers at the poll rate
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			chk_hold <= 8'h00;
			cxl_hold <= 8'h00;
		end else if (poll_tick) begin
			chk_hold <= misc_s[1] ? sat_inc(chk_hold) : 8'h00;
			cxl_hold <= misc_s[0] ? sat_inc(cxl_hold) : 8'h00;
		end
	end

	// Keypad stays live while the host is off
	assign rst_req = wd_fire || (poll_tick && misc_s[1] && host_alive
		&& pwr_mask[`HCC_M_KRST] && sat_inc(chk_hold) == LONG_TICKS);
	assign pwr_req = poll_tick && ((misc_s[1] && !host_alive && pwr_mask[`HCC_M_KON]
		&& sat_inc(chk_hold) == SHORT_TICKS) || (misc_s[0] && host_alive
		&& pwr_mask[`HCC_M_KOFF] && sat_inc(cxl_hold) == LONG_TICKS));

	// Pulse sequencer; a request while a pulse runs is dropped
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state       <= HCC_P_IDLE;
			pulse_cnt   <= 8'h00;
			sense_start <= 1'b0;
		end else begin
			unique case (state)
				HCC_P_IDLE: begin
					if (rst_req) begin
						state     <= HCC_P_RST;
						pulse_cnt <= RST_TICKS;
					end else if (pwr_req && pulse_len == `HCC_PULSE_HLD) begin
						state       <= HCC_P_HOLD;
						sense_start <= host_alive;
					end else if (pwr_req) begin
						state     <= HCC_P_PWR;
						pulse_cnt <= pulse_len;
					end
				end
				HCC_P_RST, HCC_P_PWR: begin
					if (poll_tick) begin
						pulse_cnt <= 8'(pulse_cnt - 8'h01);
						if (pulse_cnt == 8'h01) begin
							state <= HCC_P_IDLE;
						end
					end
				end
				HCC_P_HOLD: begin
					if (host_alive != sense_start) begin
						state <= HCC_P_IDLE;
					end
				end
			endcase
		end
	end

	// Idle level of each line, learned only while it floats
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_idle <= 1'b1;
			pwr_idle <= 1'b1;
		end else if (state == HCC_P_IDLE) begin
			rst_idle <= pin_s[3];
			pwr_idle <= pin_s[2];
		end
	end

	// Active level: opposite of the idle level, or set by the invert bits
	assign rst_act   = pwr_mask[`HCC_M_AUTO] ? !rst_idle : pwr_mask[`HCC_M_RINV];
	assign pwr_act   = pwr_mask[`HCC_M_AUTO] ? !pwr_idle : pwr_mask[`HCC_M_PINV];
	assign rst_drive = (state == HCC_P_RST);
	assign pwr_drive = (state == HCC_P_PWR) || (state == HCC_P_HOLD);

	// Pin value and configuration
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			for (int k = 0; k < `HCC_PIN_N; k++) begin
				pin_val[k] <= 8'h00;
				pin_cfg[k] <= (k == 1) ? `HCC_CFG_SENSE : `HCC_CFG_DEF;
			end
		end else if (ex_pin) begin
			pin_val[b0[2:0]] <= b1;
			if (cmd_len == 8'h03) begin
				pin_cfg[b0[2:0]] <= b2[3:0];
			end
		end
	end

	// PWM step, 100 steps per 10 ms period
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			step <= 7'h00;
		end else if (pwm_tick) begin
			step <= (step == STEP_LAST) ? 7'h00 : 7'(step + 7'h01);
		end
	end

	// Pin drivers: user pins follow their mode, default pins their function
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_pin_out <= 5'h00;
			o_pin_oe  <= 5'h00;
		end else begin
			for (int i = 0; i < `HCC_PIN_N; i++) begin
				if (pin_cfg[i][3]) begin
					{o_pin_oe[i], o_pin_out[i]} <= drive_of(pin_cfg[i][2:0], pwm_level(pin_val[i], step));
				end else if (i == 2) begin
					{o_pin_oe[i], o_pin_out[i]} <= {pwr_drive, pwr_act};
				end else if (i == 3) begin
					{o_pin_oe[i], o_pin_out[i]} <= {rst_drive, rst_act};
				end else begin
					{o_pin_oe[i], o_pin_out[i]} <= 2'b00;
				end
			end
		end
	end

	// Edge capture; a read of that pin's register clears, a new edge in that cycle still lands
	// The first poll only learns the levels, so pulled-up pins show no edge after reset
	assign rise_set = (poll_tick && pin_primed) ? (pin_s & ~pin_state) : 5'h00;
	assign fall_set = (poll_tick && pin_primed) ? (~pin_s & pin_state) : 5'h00;
	assign pin_clr  = (i_rd && pin_hit) ? 5'(5'h01 << pidx) : 5'h00;
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pin_state  <= 5'h00;
			pin_primed <= 1'b0;
			pin_rise   <= 5'h00;
			pin_fall   <= 5'h00;
		end else begin
			if (poll_tick) begin
				pin_state  <= pin_s;
				pin_primed <= 1'b1;
			end
			pin_rise <= (pin_rise & ~pin_clr) | rise_set;
			pin_fall <= (pin_fall & ~pin_clr) | fall_set;
		end
	end

	// Display text; characters past column 15 are dropped, not wrapped
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			for (int k = 0; k < `HCC_DISP_N; k++) begin
				disp[k] <= 8'h20;
			end
		end else if (ex_text) begin
			for (int k = 0; k < `HCC_COLS; k++) begin
				if (k < int'(cmd_len) - 2 && int'(b0) + k < `HCC_COLS) begin
					disp[5'(int'(b1[0]) * `HCC_COLS + int'(b0) + k)] <= cmd_buf[k + 2];
				end
			end
		end
	end

	// Status reply bytes: seven external, mask, watchdog, six external
	assign eidx = 4'(i_addr - `HCC_A_RDAT) - ((i_addr - `HCC_A_RDAT < 7'h07) ? 4'h0 : 4'h2);

	// Read mux; unmapped and write-only addresses read zero
	always_comb begin
		rd_val = 8'h00;
		if (i_addr == `HCC_A_TYPE) begin
			rd_val = cmd_type;
		end else if (i_addr == `HCC_A_LEN) begin
			rd_val = cmd_len;
		end else if (i_addr == `HCC_A_RTYPE) begin
			rd_val = reply_type;
		end else if (i_addr == `HCC_A_RLEN) begin
			rd_val = reply_len;
		end else if (i_addr == `HCC_A_STAT) begin
			rd_val = {3'h0, o_baud_sel, host_alive, state != HCC_P_IDLE, wd_count != 8'h00, o_reply_ready};
		end else if (pin_hit) begin
			rd_val = {5'h00, pin_rise[pidx], pin_fall[pidx], pin_state[pidx]};
		end else if (buf_hit) begin
			rd_val = cmd_buf[5'(i_addr - `HCC_A_BUF)];
		end else if (rdat_hit && reply_len != 8'h00) begin
			if (i_addr == `HCC_A_RDAT + 7'h07) begin
				rd_val = pwr_mask;
			end else if (i_addr == `HCC_A_RDAT + 7'h08) begin
				rd_val = wd_count;
			end else begin
				rd_val = i_ext_status[{eidx, 3'b000} +: 8];
			end
		end else if (disp_hit) begin
			rd_val = disp[5'(i_addr - `HCC_A_DISP)];
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rdata <= 8'h00;
		end else begin
			o_rdata <= i_rd ? rd_val : 8'h00;
		end
	end

	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_resetn);

	a_ack_type: assert property (go && cmd_ok |=> reply_type == ($past(cmd_type) | `HCC_ACK))
		else $error("accepted command reply type wrong");
	a_err_keep: assert property (go && !cmd_ok |=> $stable(pwr_mask) && $stable(pulse_len) && $stable(baud_next)
		&& reply_type == ($past(cmd_type) | `HCC_ERR))
		else $error("refused command changed state");
	a_mask_load: assert property (ex_pwr |=> pwr_mask == $past(b0))
		else $error("power mask not loaded");
	a_wd_arm: assert property (ex_wdog |=> wd_count == $past(b0))
		else $error("watchdog not restarted");
	a_wd_expire: assert property (wd_fire && state == HCC_P_IDLE |=> state == HCC_P_RST && wd_count == 8'h00)
		else $error("watchdog expiry did not reset host");
	a_rst_length: assert property (state != HCC_P_RST ##1 state == HCC_P_RST |-> pulse_cnt == RST_TICKS)
		else $error("reset pulse length wrong");
	a_idle_float: assert property (state == HCC_P_IDLE && !pin_cfg[3][3] && !pin_cfg[2][3]
		|=> !o_pin_oe[3] && !o_pin_oe[2])
		else $error("control line driven while idle");
	a_rst_level: assert property (state == HCC_P_RST && !pin_cfg[3][3] |=> o_pin_oe[3] && o_pin_out[3] == $past(rst_act))
		else $error("reset line level wrong");
	a_hold_line: assert property (state == HCC_P_HOLD && host_alive == sense_start |=> state == HCC_P_HOLD)
		else $error("held power line released early");
	a_baud_wait: assert property (baud_pend && !i_reply_sent |=> $stable(o_baud_sel))
		else $error("rate changed before acknowledge");
	a_pwm_full: assert property (pin_cfg[0] == 4'h9 && pin_val[0] == `HCC_VAL_MAX |=> o_pin_oe[0] && o_pin_out[0])
		else $error("pin at 100 not driven high");
	a_edge_hold: assert property (pin_rise[4] && !(i_rd && i_addr == `HCC_A_PIN_END) |=> pin_rise[4])
		else $error("rising edge lost before query");

	c_text: cover property (ex_text);
	c_wd_fire: cover property (wd_fire);
	c_hold: cover property (state == HCC_P_HOLD ##1 state == HCC_P_IDLE);
	c_baud: cover property (baud_pend ##1 !baud_pend);
endmodule : hcc_host_ctrl
`default_nettype wire

// >>> sim/hcc_host_model.sv
// Host-side model: reports replies sent and resolves the shared pin wires
`timescale 1ns/100ps
`default_nettype none
module hcc_host_model #(
	parameter int unsigned P_ACK_DLY = 6
) (
	input  wire logic       i_ref_clk,
	input  wire logic       i_resetn,
	input  wire logic       i_reply_ready,
	input  wire logic [4:0] i_pin_out,
	input  wire logic [4:0] i_pin_oe,
	input  wire logic [4:0] i_ext,
	output logic            o_reply_sent,
	output logic      [4:0] o_pin_in
);
	int unsigned cnt;
	// Framer needs time to push a reply out; the host keeps its old rate until this pulse
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cnt <= 0;
			o_reply_sent <= 1'b0;
		end else begin
			o_reply_sent <= i_reply_ready && cnt == P_ACK_DLY;
			cnt <= (i_reply_ready && cnt <= P_ACK_DLY) ? cnt + 1 : 0;
		end
	end
	// Undriven pins fall back to the host-side level, pull-ups by default
	assign o_pin_in = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext);
endmodule : hcc_host_model
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the host control command interpreter
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic       i_ref_clk = 1'b0;
	logic       i_resetn = 1'b0;
	logic [6:0] i_addr = 7'h00;
	logic [7:0] i_wdata = 8'h00;
	logic       i_wr = 1'b0;
	logic       i_rd = 1'b0;
	logic       i_rail_sense = 1'b1;
	logic       i_key_check = 1'b0;
	logic [4:0] ext = 5'h1F;
	logic [7:0] o_rdata;
	logic [4:0] o_pin_out, o_pin_oe, pin_in;
	logic       o_reply_ready, reply_sent, o_blank, o_self_reboot, o_baud_sel, seen;
	int         fails = 0;
	int         n_checks = 0;
	// Short counts keep the watchdog and poll runs brief
	hcc_host_ctrl #(.P_POLL_CYC(20), .P_SEC_CYC(100)) DUT (.i_ref_clk, .i_resetn, .i_addr, .i_wdata,
		.i_wr, .i_rd, .o_rdata, .i_reply_sent(reply_sent), .o_reply_ready, .i_ext_status({13{8'h3C}}),
		.i_pin_in(pin_in), .o_pin_out, .o_pin_oe, .i_rail_sense, .i_key_check, .i_key_cancel(1'b0),
		.o_blank, .o_self_reboot, .o_baud_sel);
	hcc_host_model HOST (.i_ref_clk, .i_resetn, .i_reply_ready(o_reply_ready), .i_pin_out(o_pin_out),
		.i_pin_oe(o_pin_oe), .i_ext(ext), .o_reply_sent(reply_sent), .o_pin_in(pin_in));
	always #50 i_ref_clk = ~i_ref_clk;
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask : wr
	// An empty name marks a read that only clears state
	task automatic rd(input logic [6:0] a, input logic [7:0] e, input string nm);
		@(posedge i_ref_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1 if (nm != "") chk(nm, e, o_rdata);
	endtask : rd
	task automatic cmd(input logic [7:0] t, input logic [7:0] n, input logic [31:0] b, input logic [7:0] e);
		for (int k = 0; k < 4; k++) wr(7'h10 + 7'(k), b[8*k +: 8]);
		wr(7'h01, n);
		wr(7'h00, t);
		wr(7'h02, 8'h00);
		rd(7'h03, e, "reply type");
		chk("reply ready", 8'h01, {7'h00, o_reply_ready});
	endtask : cmd
	// Waits for a pin enable to reach v, then judges the enable seen
	task automatic wait_oe(input int p, input logic v, input int lim, input logic e);
		int c;
		c = 0;
		while (o_pin_oe[p] !== v && c < lim) begin
			@(posedge i_ref_clk);
			#1 c++;
		end
		chk("line enable", {7'h00, e}, {7'h00, o_pin_oe[p]});
	endtask : wait_oe
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : final_report
	task automatic t_reset;
		rd(7'h05, 8'h08, "status");
		chk("idle enables", 8'h00, {3'b000, o_pin_oe});
		$display("reset test done");
	endtask : t_reset
	// Reissue before expiry restarts the count; expiry resets once only
	task automatic t_wdog;
		cmd(8'h1D, 8'h01, 32'h0000_0005, 8'h5D);
		repeat (300) @(posedge i_ref_clk);
		cmd(8'h1D, 8'h01, 32'h0000_0005, 8'h5D);
		wait_oe(3, 1'b1, 350, 1'b0);
		wait_oe(3, 1'b1, 300, 1'b1);
		chk("reset level", 8'h00, {7'h00, o_pin_out[3]});
		wait_oe(3, 1'b0, 600, 1'b1);
		wait_oe(3, 1'b0, 100, 1'b0);
		wait_oe(3, 1'b1, 1500, 1'b0);
		$display("watchdog test done");
	endtask : t_wdog
	task automatic t_pin;
		cmd(8'h22, 8'h03, 32'h0009_6400, 8'h62);
		#200 chk("pin0 drive", 8'h03, {6'h00, o_pin_oe[0], o_pin_out[0]});
		cmd(8'h22, 8'h02, 32'h0000_0000, 8'h62);
		cmd(8'h22, 8'h02, 32'h0000_0005, 8'hE2);
		cmd(8'h22, 8'h02, 32'h0000_6500, 8'hE2);
		cmd(8'h22, 8'h03, 32'h0010_6400, 8'hE2);
		cmd(8'h1F, 8'h03, 32'h0041_0010, 8'hDF);
		cmd(8'h1F, 8'h03, 32'h0041_0200, 8'hDF);
		cmd(8'h1F, 8'h02, 32'h0000_0000, 8'hDF);
		chk("pin0 kept", 8'h02, {6'h00, o_pin_oe[0], o_pin_out[0]});
		cmd(8'h1F, 8'h04, 32'h4241_010E, 8'h5F);
		rd(7'h5E, 8'h41, "text col 14");
		rd(7'h5F, 8'h42, "text col 15");
		$display("pin and text test done");
	endtask : t_pin
	task automatic t_stat;
		cmd(8'h1C, 8'h02, 32'h0000_FF50, 8'h5C);
		cmd(8'h1E, 8'h00, 32'h0000_0000, 8'h5E);
		rd(7'h04, 8'h0F, "reply len");
		rd(7'h30, 8'h3C, "reply byte 0");
		rd(7'h37, 8'h50, "reply mask");
		rd(7'h38, 8'h00, "reply wdog");
		rd(7'h39, 8'h3C, "reply byte 9");
		i_rail_sense <= 1'b0;
		repeat (8) @(posedge i_ref_clk);
		#1 chk("blank", 8'h01, {7'h00, o_blank});
		// Short press with the host off holds the power line until the host comes up
		i_key_check <= 1'b1;
		wait_oe(2, 1'b1, 300, 1'b1);
		chk("power level", 8'h00, {7'h00, o_pin_out[2]});
		i_key_check <= 1'b0;
		i_rail_sense <= 1'b1;
		seen = 1'b0;
		repeat (8) @(posedge i_ref_clk) #1 seen |= o_self_reboot;
		chk("reboot", 8'h01, {7'h00, seen});
		chk("power released", 8'h00, {7'h00, o_pin_oe[2]});
		$display("status test done");
	endtask : t_stat
	task automatic t_edge_baud;
		rd(7'h0C, 8'h00, "");
		ext[4] <= 1'b0;
		repeat (100) @(posedge i_ref_clk);
		ext[4] <= 1'b1;
		repeat (100) @(posedge i_ref_clk);
		rd(7'h0C, 8'h07, "pin4 edges");
		rd(7'h0C, 8'h01, "pin4 cleared");
		cmd(8'h21, 8'h01, 32'h0000_0001, 8'h61);
		chk("old rate", 8'h00, {7'h00, o_baud_sel});
		repeat (12) @(posedge i_ref_clk);
		chk("new rate", 8'h01, {7'h00, o_baud_sel});
		chk("reply done", 8'h00, {7'h00, o_reply_ready});
		$display("edge and baud test done");
	endtask : t_edge_baud
	// Hang guard, far beyond the few thousand cycles the tests need
	initial begin
		#3000000;
		fails++;
		final_report();
	end
	initial begin
		repeat (16) @(posedge i_ref_clk);
		i_resetn <= 1'b1;
		// Rail sense needs two clocks through its synchroniser before status shows it
		repeat (2) @(posedge i_ref_clk);
		t_reset();
		t_wdog();
		t_pin();
		t_stat();
		t_edge_baud();
		final_report();
	end
endmodule : tb_top
`default_nettype wire
